//--- hw/apex_pkg.sv
// Purpose: Shared constants and carrier types for the apex position readout sequencer
// Assumes: 40 MHz system clock, AXI4-Lite register access
// Notes: Times are kept in their own units; cycle counts derive from the clock rate
package apex_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;
  // Conversion cycle rate and sub-terms
  localparam int unsigned CONV_RATE_HZ = 10_000;
  localparam int unsigned CONV_PERIOD_CYC = CLK_HZ / CONV_RATE_HZ;
  localparam int unsigned HOLD_US = 10;
  localparam int unsigned HOLD_CYC = HOLD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SETTLE_US = 45;
  localparam int unsigned SETTLE_CYC = SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SAMPLE_AT_CYC = CONV_PERIOD_CYC - SETTLE_CYC;
  localparam int unsigned LOAD_DELAY_NS = 200;
  localparam int unsigned LOAD_DELAY_CYC = (LOAD_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Readout shift clock 5 MHz
  localparam int unsigned SHIFT_HZ = 5_000_000;
  localparam int unsigned SHIFT_DIV = CLK_HZ / SHIFT_HZ;
  localparam int unsigned CLK_DELAY_NS = 50;
  localparam int unsigned CLK_DELAY_CYC = (CLK_DELAY_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam logic [6:0] BIT_PRESET = 7'd21;
  localparam logic [6:0] BIT_END = 7'd64;
  localparam int unsigned FRAME_BITS = 43;
  localparam int unsigned LOAD_STEP = 4;
  localparam int unsigned SHIFT_STEP = 5;
  // Readout-active indicator one-shot
  localparam int unsigned ONESHOT_US = 100;
  localparam int unsigned ONESHOT_CYC = ONESHOT_US * (CLK_HZ / 1_000_000);
  // Display scan
  localparam int unsigned SCAN_HZ = 10_000;
  localparam int unsigned SCAN_CYC = CLK_HZ / SCAN_HZ;
  localparam logic [3:0] SCAN_LAST = 4'h9;

  localparam int unsigned POS_W = 14;
  localparam int unsigned ADC_W = 10;
  localparam int unsigned MUX_W = 3;
  localparam logic [2:0] VEL_CH_FOCUS = 3'h6;
  localparam logic [2:0] VEL_CH_ROT = 3'h7;

  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ADC = 8'h08;
  localparam logic [7:0] REG_POS_FOCUS = 8'h0C;
  localparam logic [7:0] REG_POS_ROT = 8'h10;
  localparam logic [7:0] REG_VEL = 8'h14;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic focus_upper_limit;
    logic focus_lower_limit;
    logic rot_cw_limit;
    logic rot_ccw_limit;
    logic ring_retracted_switch;
    logic ring_extended_switch;
    logic [7:0] pin_switch;
  } discretes_t;

  typedef struct packed {
    logic [ADC_W-1:0] adc;
    logic [MUX_W-1:0] mux;
    logic [5:0] disc;
    logic [ADC_W-1:0] vel;
    logic [POS_W-1:0] pos;
  } frame_t;

  typedef struct packed {
    logic clk;
    logic data;
    logic load_n;
    logic enable;
  } serial_t;

endpackage

//--- hw/apex_position_readout_sequencer.sv
// Purpose: Apex readout sequencer: time base, A/D sequencing, two serial readouts, faults, display
// Assumes: Outside signals asynchronous except rst and AXI4-Lite; 40 MHz clk; synchronous active-high reset
// Notes: Serial shift clock is derived from clk; the axis readouts run independently
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module apex_position_readout_sequencer
  import apex_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converters
  output logic sample_hold_control_ff,
  output logic adc_convert,
  input wire logic conversion_done_n,
  input wire logic [ADC_W-1:0] adc_data,
  output logic [MUX_W-1:0] mux_address_bits,
  input wire logic [POS_W-1:0] focus_angle,
  input wire logic [POS_W-1:0] rot_angle,
  output logic [1:0] angle_inhibit,
  // Controller link, index 0 focus, 1 rotation
  input wire logic [1:0] readout_request,
  output serial_t focus_link,
  output serial_t rot_link,
  // Discretes (active low contacts)
  input wire discretes_t discretes_n,
  output logic apex_fault_alarm,
  output logic [3:0] limit_lines,
  // Indicators and display
  output logic focus_readout_active_led,
  output logic rotation_readout_active_led,
  output logic converter_active_led,
  output logic [2:0] digit_octal,
  output logic [9:0] digit_enable
);

  // Two-stage synchronisers for the request, converter, discrete and angle inputs
  localparam int unsigned SYNC_W = 2 + 1 + $bits(discretes_t) + 2 * POS_W + ADC_W;
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;
  assign raw_in = {readout_request, conversion_done_n, discretes_n, focus_angle, rot_angle, adc_data};

  always_ff @(posedge clk)
  begin
    meta_r <= raw_in;
    sync_r <= meta_r;
  end

  logic [1:0] req_s;
  logic done_n_s;
  discretes_t disc_n_s;
  logic [POS_W-1:0] pos_s [2];
  logic [ADC_W-1:0] adc_s;
  assign {req_s, done_n_s, disc_n_s, pos_s[0], pos_s[1], adc_s} = sync_r;

  // Time base: free 10 kHz cycle, hold term then sample term
  logic [15:0] tb_r;
  logic sample_edge;
  logic hold_end;
  assign hold_end = tb_r == 16'(HOLD_CYC);
  assign sample_edge = tb_r == 16'(SAMPLE_AT_CYC);

  always_ff @(posedge clk)
  begin
    if (rst || tb_r == 16'(CONV_PERIOD_CYC - 1))
      tb_r <= '0;
    else
      tb_r <= tb_r + 16'd1;
  end

  // Sample/hold and conversion start
  logic busy_r;
  logic done_prev_r;
  logic [3:0] ld_dly_r;
  logic load_strobe;
  logic done_fall;
  assign done_fall = done_prev_r && !done_n_s;
  assign load_strobe = ld_dly_r == 4'd1;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sample_hold_control_ff <= 1'b0;
      adc_convert <= 1'b0;
      busy_r <= 1'b0;
      done_prev_r <= 1'b1;
      ld_dly_r <= '0;
    end
    else
    begin
      done_prev_r <= done_n_s;
      if (tb_r == '0)
        sample_hold_control_ff <= 1'b1;
      else if (sample_edge)
        sample_hold_control_ff <= 1'b0;
      adc_convert <= hold_end;
      busy_r <= hold_end || (busy_r && !load_strobe && !sample_edge);
      if (done_fall && busy_r)
        ld_dly_r <= 4'(LOAD_DELAY_CYC + 1);
      else if (ld_dly_r != '0)
        ld_dly_r <= ld_dly_r - 4'd1;
    end
  end

  // Holding register, mux address and velocity registers
  logic [ADC_W-1:0] converter_holding_register;
  logic [MUX_W-1:0] mux_address_counter;
  logic [ADC_W-1:0] vel_r [2];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      converter_holding_register <= '0;
      mux_address_counter <= '0;
      vel_r[0] <= '0;
      vel_r[1] <= '0;
    end
    else if (load_strobe)
    begin
      converter_holding_register <= adc_s;
      mux_address_counter <= mux_address_counter + 3'd1;
      if (mux_address_counter == VEL_CH_FOCUS)
        vel_r[0] <= adc_s;
      if (mux_address_counter == VEL_CH_ROT)
        vel_r[1] <= adc_s;
    end
  end

  // Discretes: active low, hysteresis modelled as two-sample agreement
  discretes_t disc_prev_r;
  discretes_t disc_r;
  always_ff @(posedge clk)
  begin
    disc_prev_r <= ~disc_n_s;
    if (rst)
      disc_r <= '0;
    else
      disc_r <= (disc_r & (disc_prev_r | ~disc_n_s)) | (disc_prev_r & ~disc_n_s);
  end

  // Fault detection and direct limit lines
  logic pin_multi;
  assign pin_multi = (disc_r.pin_switch & (disc_r.pin_switch - 8'd1)) != 8'd0;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      apex_fault_alarm <= 1'b0;
      limit_lines <= '0;
    end
    else
    begin
      apex_fault_alarm <= (disc_r.focus_upper_limit && disc_r.focus_lower_limit) || pin_multi;
      limit_lines <= {disc_r.focus_upper_limit, disc_r.focus_lower_limit,
                      disc_r.rot_cw_limit, disc_r.rot_ccw_limit};
    end
  end

  // Shared 5 MHz shift-clock phase
  logic [2:0] div_r;
  logic tick;
  assign tick = div_r == 3'(SHIFT_DIV - 1);
  always_ff @(posedge clk)
  begin
    if (rst || tick)
      div_r <= '0;
    else
      div_r <= div_r + 3'd1;
  end

  // Per-axis readout sections, independent of each other
  logic [POS_W-1:0] pos_hold [2];
  logic [1:0] active_v;
  logic [1:0] ser_data;
  logic [1:0] ser_clk;
  logic [1:0] ser_load_n;
  logic [5:0] monitor_disc;
  assign monitor_disc = {disc_r.focus_upper_limit, disc_r.focus_lower_limit,
                         disc_r.rot_cw_limit, disc_r.rot_ccw_limit,
                         disc_r.ring_retracted_switch, disc_r.ring_extended_switch};

  for (genvar ax = 0; ax < 2; ax++)
  begin : g_axis
    logic pend_r;
    logic readout_control_ff;
    logic [5:0] load_timing_shift_chain;
    logic [6:0] unload_bit_counter;
    logic [FRAME_BITS-1:0] unload_r;
    logic req_prev_r;
    logic shifting;
    logic gate_clk;
    logic [CLK_DELAY_CYC:0] clock_delay_chain;
    logic [15:0] os_r;
    logic [POS_W-1:0] pos_mon;
    frame_t fr;
    logic readout_gating_logic;

    assign pos_mon = {~pos_s[ax][POS_W-1], pos_s[ax][POS_W-2:0]};
    assign fr = '{adc: converter_holding_register, mux: mux_address_counter,
                  disc: monitor_disc, vel: vel_r[ax], pos: pos_mon};
    assign shifting = load_timing_shift_chain[SHIFT_STEP-1];
    assign readout_gating_logic = pend_r && !busy_r && !hold_end;
    assign gate_clk = readout_control_ff && shifting && div_r < 3'(SHIFT_DIV / 2);

    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        req_prev_r <= 1'b0;
        pend_r <= 1'b0;
        readout_control_ff <= 1'b0;
        load_timing_shift_chain <= '0;
        unload_bit_counter <= BIT_PRESET;
        unload_r <= '0;
        clock_delay_chain <= '0;
        ser_load_n[ax] <= 1'b1;
        os_r <= '0;
        pos_hold[ax] <= '0;
      end
      else
      begin
        req_prev_r <= req_s[ax];
        clock_delay_chain <= {clock_delay_chain[CLK_DELAY_CYC-1:0], gate_clk};
        if (req_s[ax] && !req_prev_r && !pend_r && !readout_control_ff)
          pend_r <= 1'b1;
        if (readout_gating_logic && tick)
        begin
          pend_r <= 1'b0;
          readout_control_ff <= 1'b1;
          unload_bit_counter <= BIT_PRESET;
        end
        ser_load_n[ax] <= 1'b1;
        if (readout_control_ff && tick)
        begin
          load_timing_shift_chain <= {load_timing_shift_chain[4:0], 1'b1};
          if (load_timing_shift_chain[LOAD_STEP-2] && !load_timing_shift_chain[LOAD_STEP-1])
          begin
            unload_r <= fr;
            pos_hold[ax] <= pos_s[ax];
            ser_load_n[ax] <= 1'b0;
          end
          if (shifting)
          begin
            unload_r <= {unload_r[FRAME_BITS-2:0], 1'b0};
            unload_bit_counter <= unload_bit_counter + 7'd1;
            if (unload_bit_counter == BIT_END - 7'd1)
            begin
              readout_control_ff <= 1'b0;
              load_timing_shift_chain <= '0;
            end
          end
        end
        if (readout_control_ff)
          os_r <= 16'(ONESHOT_CYC);
        else if (os_r != '0)
          os_r <= os_r - 16'd1;
      end
    end

    assign active_v[ax] = readout_control_ff;
    assign ser_clk[ax] = clock_delay_chain[CLK_DELAY_CYC];
    assign ser_data[ax] = unload_r[FRAME_BITS-1];
    logic led_w;
    assign led_w = os_r != '0;
    if (ax == 0)
    begin : g_f
      always_ff @(posedge clk)
        focus_readout_active_led <= !rst && led_w;
    end
    else
    begin : g_r
      always_ff @(posedge clk)
        rotation_readout_active_led <= !rst && led_w;
    end
  end

  // Link outputs and converter inhibits, all registered
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      focus_link <= '{clk: 1'b0, data: 1'b0, load_n: 1'b1, enable: 1'b0};
      rot_link <= '{clk: 1'b0, data: 1'b0, load_n: 1'b1, enable: 1'b0};
      angle_inhibit <= '0;
      converter_active_led <= 1'b0;
      mux_address_bits <= '0;
    end
    else
    begin
      focus_link <= '{clk: ser_clk[0], data: ser_data[0], load_n: ser_load_n[0],
                      enable: active_v[0]};
      rot_link <= '{clk: ser_clk[1], data: ser_data[1], load_n: ser_load_n[1],
                    enable: active_v[1]};
      angle_inhibit <= active_v;
      converter_active_led <= busy_r;
      mux_address_bits <= mux_address_counter;
    end
  end

  // Display scan: 10 kHz, ten octal digits from both positions
  logic [15:0] scan_div_r;
  logic [3:0] scan_r;
  logic [27:0] disp_word;
  logic [4:0] dsh;
  assign disp_word = {pos_hold[1], pos_hold[0]};
  assign dsh = 5'(scan_r) * 5'd3;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scan_div_r <= '0;
      scan_r <= '0;
      digit_octal <= '0;
      digit_enable <= '0;
    end
    else
    begin
      scan_div_r <= (scan_div_r == 16'(SCAN_CYC - 1)) ? 16'd0 : scan_div_r + 16'd1;
      if (scan_div_r == 16'(SCAN_CYC - 1))
        scan_r <= (scan_r == SCAN_LAST) ? 4'd0 : scan_r + 4'd1;
      digit_octal <= 3'(disp_word >> dsh);
      digit_enable <= 10'(10'd1 << scan_r);
    end
  end

  // AXI4-Lite slave: one write and one read at a time
  logic [31:0] ctrl_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wen_r;
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  logic rd_ok;
  // Read selection; unmapped offsets read as zero
  assign rd_ok = s_axi_araddr <= REG_VEL && s_axi_araddr[1:0] == 2'b00;
  assign status_word = 32'({apex_fault_alarm, busy_r, active_v, mux_address_counter});
  assign rd_mux = (s_axi_araddr == REG_CTRL) ? ctrl_r
                : (s_axi_araddr == REG_STATUS) ? status_word
                : (s_axi_araddr == REG_ADC) ? 32'(converter_holding_register)
                : (s_axi_araddr == REG_POS_FOCUS) ? 32'(pos_hold[0])
                : (s_axi_araddr == REG_POS_ROT) ? 32'(pos_hold[1])
                : (s_axi_araddr == REG_VEL) ? {6'd0, vel_r[1], 6'd0, vel_r[0]}
                : 32'h0000_0000;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wen_r <= 1'b0;
      ctrl_r <= CTRL_RESET;
    end
    else
    begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready <= !w_hold_r && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0]; // Data only valid at its own handshake
        wen_r <= s_axi_wstrb[0];
      end
      if (aw_hold_r && w_hold_r && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bresp <= (awaddr_r == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
        if (awaddr_r == REG_CTRL && wen_r)
          ctrl_r <= {24'd0, wdata_r};
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // apex_position_readout_sequencer
`default_nettype wire

//--- sim/apex_seq_assertions.sv
// Purpose: Port checker for the apex readout sequencer
// Assumes: One clk domain, synchronous rst
// Notes: Watches the focus link; the rotation link is built alike
`timescale 1ns/1ps
`default_nettype none
module apex_seq_checker
  import apex_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sample_hold_control_ff,
  input wire logic adc_convert,
  input wire logic [MUX_W-1:0] mux_address_bits,
  input wire logic [1:0] angle_inhibit,
  input wire serial_t focus_link,
  input wire logic apex_fault_alarm,
  input wire logic [3:0] limit_lines,
  input wire logic focus_readout_active_led,
  input wire logic converter_active_led
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic sh_d_r, lk_d_r, seen_r;
  logic [12:0] cnt_r;
  logic [6:0] bits_r;
  wire hold_rise = sample_hold_control_ff && !sh_d_r;
  // Cycles since hold began; link clock rises since the frame began
  always_ff @(posedge clk)
  begin
    sh_d_r <= sample_hold_control_ff;
    lk_d_r <= focus_link.clk;
    seen_r <= !rst && (seen_r || hold_rise);
    cnt_r <= hold_rise ? 13'd1 : cnt_r + 13'd1;
    bits_r <= $rose(focus_link.enable) ? 7'd0 : bits_r + 7'(focus_link.clk && !lk_d_r);
  end
  hold_period_a: assert property (hold_rise && seen_r |-> cnt_r == CONV_PERIOD_CYC)
    else $error("hold period off");
  convert_delay_a: assert property (adc_convert && seen_r |->
    cnt_r inside {[HOLD_CYC-1:HOLD_CYC+3]}) else $error("convert start off");
  sample_return_a: assert property ($fell(sample_hold_control_ff) && seen_r |->
    cnt_r inside {[SAMPLE_AT_CYC-1:SAMPLE_AT_CYC+3]}) else $error("sample return off");
  mux_step_a: assert property ($changed(mux_address_bits) |-> sample_hold_control_ff &&
    mux_address_bits == 3'($past(mux_address_bits) + 3'd1)) else $error("mux step off");
  start_idle_a: assert property ($rose(focus_link.enable) |->
    !converter_active_led ##[0:1] angle_inhibit[0]) else $error("readout start off");
  load_pulse_a: assert property (!focus_link.load_n |->
    focus_link.enable ##1 focus_link.load_n) else $error("load strobe off");
  frame_bits_a: assert property ($fell(focus_link.enable) |->
    ##8 bits_r == FRAME_BITS) else $error("frame length off");
  fault_alarm_a: assert property (limit_lines[3] && limit_lines[2] |->
    ##[0:3] apex_fault_alarm) else $error("alarm missing");
  active_led_a: assert property ($rose(angle_inhibit[0]) |->
    ##[0:3] focus_readout_active_led) else $error("active lamp missing");
endmodule // apex_seq_checker
bind apex_position_readout_sequencer apex_seq_checker chk (.clk, .rst,
  .sample_hold_control_ff, .adc_convert, .mux_address_bits, .angle_inhibit, .focus_link,
  .apex_fault_alarm, .limit_lines, .focus_readout_active_led, .converter_active_led);
`default_nettype wire

//--- sim/apex_ctrl_model.sv
// Purpose: Controller stand-in that requests and receives serial frames
// Assumes: Link clock is sampled by the system clock
// Notes: The bench commands the request level through want
`timescale 1ns/1ps
`default_nettype none
module apex_ctrl_model
  import apex_pkg::*;
(
  input wire logic clk,
  input wire logic want,
  input wire serial_t link,
  output logic req,
  output frame_t frame,
  output logic [6:0] nbits,
  output logic [3:0] nframes
);
  logic lk_d_r, en_d_r;
  initial
  begin
    req = 1'b0;
    nbits = '0;
    nframes = '0;
  end
  // Shift in one bit per received clock, count whole frames
  always @(posedge clk)
  begin
    req <= want;
    lk_d_r <= link.clk;
    en_d_r <= link.enable;
    if (link.enable && !en_d_r)
      nbits <= '0;
    else if (link.clk && !lk_d_r)
    begin
      frame <= {frame[FRAME_BITS-2:0], link.data};
      nbits <= nbits + 7'd1;
    end
    if (!link.enable && en_d_r)
      nframes <= nframes + 4'd1;
  end
endmodule // apex_ctrl_model
`default_nettype wire

//--- sim/apex_position_readout_sequencer_tb.sv
// Purpose: Self-checking bench for the apex readout sequencer
// Assumes: Converter and controllers are modelled here
// Notes: Velocity checks wait for a full mux sweep
`timescale 1ns/1ps
`default_nettype none
module apex_position_readout_sequencer_tb;
  import apex_pkg::*;
  localparam logic [9:0] ADC_BASE = 10'h2C0;
  logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic sample_hold_control_ff, adc_convert, conversion_done_n, apex_fault_alarm;
  logic focus_readout_active_led, rotation_readout_active_led, converter_active_led;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, limit_lines;
  logic [1:0] s_axi_bresp, s_axi_rresp, angle_inhibit, want, rs;
  wire [1:0] readout_request;
  logic [9:0] adc_data, digit_enable;
  logic [2:0] mux_address_bits, digit_octal;
  logic [13:0] focus_angle, rot_angle;
  serial_t focus_link, rot_link;
  discretes_t discretes_n;
  frame_t fr [2];
  logic [6:0] nb [2];
  logic [3:0] nfr [2];
  int fail_count, n_compared, cyc, ccnt;
  apex_position_readout_sequencer DUT (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sample_hold_control_ff, .adc_convert, .conversion_done_n, .adc_data, .mux_address_bits,
    .focus_angle, .rot_angle, .angle_inhibit, .readout_request, .focus_link, .rot_link,
    .discretes_n, .apex_fault_alarm, .limit_lines, .focus_readout_active_led,
    .rotation_readout_active_led, .converter_active_led, .digit_octal, .digit_enable);
  apex_ctrl_model focus_ctrl (.clk, .want(want[0]), .link(focus_link),
    .req(readout_request[0]), .frame(fr[0]), .nbits(nb[0]), .nframes(nfr[0]));
  apex_ctrl_model rot_ctrl (.clk, .want(want[1]), .link(rot_link),
    .req(readout_request[1]), .frame(fr[1]), .nbits(nb[1]), .nframes(nfr[1]));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Run limit, and a converter that takes about 32 us and tags words with the channel
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (adc_convert)
    begin
      ccnt <= 1300;
      adc_data <= ADC_BASE | {7'h0, mux_address_bits};
    end
    else if (ccnt > 0)
      ccnt <= ccnt - 1;
    conversion_done_n <= !(ccnt inside {[1:10]});
    if (cyc == 90000)
    begin
      fail_count++;
      $display("unexpected run length: expected under 90000, seen %0d", cyc);
      close_out();
    end
  end
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check("write response", er, s_axi_bresp);
  endtask
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    check("read data", ed, rd);
    check("read response", er, rs);
  endtask
  task automatic frame_chk(input int ax, input logic [29:0] e, input logic poke);
    logic [3:0] n0;
    int t0;
    n0 = nfr[ax];
    t0 = cyc;
    want[ax] <= 1'b1;
    if (poke)
    begin
      wait (focus_link.enable);
      wait_cyc(40);
      want[ax] <= 1'b0;
      wait_cyc(8);
      want[ax] <= 1'b1;
    end
    while (nfr[ax] == n0) @(posedge clk);
    want[ax] <= 1'b0;
    check("latency within 45 us", 1, (cyc - t0) <= 45 * 40);
    check("bit count", FRAME_BITS, nb[ax]);
    check("converted word", ADC_BASE | {7'h0, 3'(fr[ax].mux - 3'd1)}, fr[ax].adc);
    check("frame tail", e, fr[ax][29:0]);
    if (poke)
    begin
      wait_cyc(2000);
      check("frame total", n0 + 4'd1, nfr[ax]);
    end
    wait_cyc(2); // Request line low long enough to give the next call a fresh edge
  endtask
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    want = '0;
    conversion_done_n = 1'b1;
    adc_data = '0;
    discretes_n = '1;
    focus_angle = 14'h0000;
    rot_angle = 14'h1555;
    {fail_count, n_compared, cyc, ccnt} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wait_cyc(4);
    reg_chk(REG_CTRL, CTRL_RESET, RESP_OKAY);
    axi_wr(REG_CTRL, 32'h1234_56A5, RESP_OKAY);
    reg_chk(REG_CTRL, 32'h0000_00A5, RESP_OKAY);
    axi_wr(REG_STATUS, 32'h0000_00FF, RESP_SLVERR);
    reg_chk(8'h40, 32'h0000_0000, RESP_SLVERR);
    reg_chk(8'h06, 32'h0000_0000, RESP_SLVERR);
    $display("register test done");
    discretes_n.focus_upper_limit <= 1'b0;
    discretes_n.rot_ccw_limit <= 1'b0;
    wait_cyc(10);
    check("limit lines", 4'b1001, limit_lines);
    check("alarm", 0, apex_fault_alarm);
    discretes_n.focus_lower_limit <= 1'b0;
    wait_cyc(10);
    check("alarm", 1, apex_fault_alarm);
    discretes_n.focus_lower_limit <= 1'b1;
    discretes_n.pin_switch <= 8'hF6;
    wait_cyc(10);
    check("alarm", 1, apex_fault_alarm);
    discretes_n.pin_switch <= 8'hFE;
    wait_cyc(10);
    check("alarm", 0, apex_fault_alarm);
    check("one digit lit", 1, $onehot(digit_enable));
    $display("discretes test done");
    wait_cyc(9 * CONV_PERIOD_CYC);
    reg_chk(REG_VEL, {6'h0, ADC_BASE | 10'h7, 6'h0, ADC_BASE | 10'h6}, RESP_OKAY);
    frame_chk(0, {6'h24, ADC_BASE | 10'h6, 14'h2000}, 1'b0);
    focus_angle <= 14'h3FFF;
    frame_chk(0, {6'h24, ADC_BASE | 10'h6, 14'h1FFF}, 1'b1);
    fork
      frame_chk(0, {6'h24, ADC_BASE | 10'h6, 14'h1FFF}, 1'b0);
      frame_chk(1, {6'h24, ADC_BASE | 10'h7, 14'h3555}, 1'b0);
    join
    check("rotation lamp", 1, rotation_readout_active_led);
    wait_cyc(4100);
    check("rotation lamp", 0, rotation_readout_active_led);
    for (int k = 0; k < 10; k++)
      if (digit_enable[k])
        check("digit", 3'({2'b00, rot_angle, focus_angle} >> (3 * k)), digit_octal);
    $display("readout test done");
    close_out();
  end
endmodule // apex_position_readout_sequencer_tb
`default_nettype wire
